/* File: hw/smb_map.svh */
// register offsets, field positions, reset values and timing counts of the serial bus block
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SMB_OFF_CTRL 8'h00
`define SMB_OFF_CFG 8'h04
`define SMB_OFF_DATA 8'h08
`define SMB_OFF_OWN 8'h0C
`define SMB_OFF_MASK 8'h10
// ------------------------------------------------------------
// control register bit positions
// ------------------------------------------------------------
`define SMB_CTRL_SI 0
`define SMB_CTRL_ACK 1
`define SMB_CTRL_STO 4
`define SMB_CTRL_STA 5
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SMB_OWN_RST 7'h00
`define SMB_MASK_RST 7'h7F
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SMB_CLK_MHZ 100
`define SMB_SCL_HALF_NS 1250
`define SMB_HALF_CYC ((`SMB_SCL_HALF_NS * `SMB_CLK_MHZ + 999) / 1000)
`define SMB_LAST_BIT 4'h7
`endif

/* File: hw/smb_pkg.sv */
// types shared by the serial bus block
package smb_pkg;
	// engine states, gray along idle-start-bits-ack-hold
	typedef enum logic [2:0] {
		SMB_IDLE = 3'h0,
		SMB_START = 3'h1,
		SMB_BITS = 3'h3,
		SMB_ACK = 3'h2,
		SMB_HOLD = 3'h6,
		SMB_STOP = 3'h7,
		SMB_RSTART = 3'h5
	} smb_state_type;
	// control/status register, bit 7 down to bit 0
	typedef struct packed {
		logic master;
		logic tx;
		logic start_request;
		logic stop_request;
		logic ack_request_flag;
		logic arbitration_lost_flag;
		logic ack;
		logic si;
	} smb_ctrl_type;
	// configuration register
	typedef struct packed {
		logic hw_ack_enable;
		logic slave_inhibit;
		logic enable;
	} smb_cfg_type;
	// register write request from the bus slave
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} smb_req_type;
	// whole state of the core
	typedef struct packed {
		smb_state_type state;
		smb_ctrl_type ctrl;
		smb_cfg_type cfg;
		logic [6:0] own;
		logic [6:0] mask;
		logic [7:0] data;
		logic [7:0] shift;
		logic samp;
		logic [3:0] bitcnt;
		logic [7:0] tmr;
		logic ph;
		logic scl_low;
		logic sda_low;
		logic scl_d;
		logic sda_d;
		logic busy;
		logic wrote;
		logic pre_ack;
		logic sw_ack;
		logic addr_ph;
		logic mute_pend;
		logic stop_ctx;
	} smb_core_type;
endpackage

/* File: hw/smb_sync.sv */
// two flip-flop synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
`default_nettype none
module smb_sync #(
	parameter int W = 2
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} smb_sync_st_type;
	smb_sync_st_type st_r; // stage registers
	smb_sync_st_type st_nxt; // next value
	// ------------------------------------------------------------
	// chain: first stage feeds only the second
	// ------------------------------------------------------------
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	// idle bus level is high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
endmodule
`default_nettype wire

/* File: hw/smb_apb.sv */
// apb slave front end: decode, zero-wait answer, registered read data
`timescale 1ns/100ps
`default_nettype none
`include "smb_map.svh"
module smb_apb (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output smb_pkg::smb_req_type req,
	input wire logic [31:0] rd_data
);
	typedef struct packed {
		logic [31:0] prdata;
	} smb_apb_st_type;
	smb_apb_st_type st_r; // read data register
	smb_apb_st_type st_nxt; // next value
	logic hit; // address maps to a register
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	always_comb begin
		hit = (paddr == `SMB_OFF_CTRL) || (paddr == `SMB_OFF_CFG) ||
			(paddr == `SMB_OFF_DATA) || (paddr == `SMB_OFF_OWN) ||
			(paddr == `SMB_OFF_MASK);
		req.wr = psel & penable & pwrite & hit;
		req.addr = paddr;
		req.wdata = pwdata;
	end
	// capture read data in the setup cycle, zero for unmapped
	always_comb begin
		st_nxt = st_r;
		if (psel && !penable && !pwrite) begin
			st_nxt.prdata = hit ? rd_data : 32'h0000_0000;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign prdata = st_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
endmodule
`default_nettype wire

/* File: hw/smb_core.sv */
// two-wire serial bus controller: master and slave engine with apb registers
// ------------------------------------------------------------
// Overview of operation
// - slave receives address, transmits data bytes after
// - start plus address enters slave receiver
// - no hw ack: address raises flag, ack request
// - hw ack: matching address acked, flag after
// - rejected address: silent until next start
// - data written after address: slave transmits
// - master ack after each byte, reported
// - slave transmitter left on stop or on a new start
// - no data written: back to slave receiver
// - transmit flag always posted after ack cycle
// - status nibble: master, tx, start, stop
// - start generated shows 1110, then address
// - nacked master byte: restart or stop
// - acked byte: next, stop, restart, receive
// - start and stop: stop then new start
// - master byte received, software acks, continue
// - last byte: nack with stop and start
// - data written in receiver: become transmitter
// - ack bit one sends ack, zero nack
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "smb_map.svh"
module smb_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	localparam logic [7:0] HALF = 8'(`SMB_HALF_CYC); // half clock period in cycles
	smb_pkg::smb_core_type c; // current state
	smb_pkg::smb_core_type n; // next state
	smb_pkg::smb_req_type req; // register write request
	logic [31:0] rd_data; // read mux
	logic [1:0] pin_s; // synchronised clock and data lines
	logic scl_s; // clock line level
	logic sda_s; // data line level
	logic rise; // clock line rose
	logic fall; // clock line fell
	logic start_ev; // start seen on the bus
	logic stop_ev; // stop seen on the bus
	logic si_clr; // software clears the flag
	logic tdone; // half period elapsed
	logic match; // received address hits own address
	logic [7:0] rx_byte; // byte completed at eighth fall
	// ------------------------------------------------------------
	// pin synchronisers and bus register slave
	// ------------------------------------------------------------
	smb_sync #(.W(2)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.d({scl_i, sda_i}),
		.q(pin_s)
	);
	smb_apb u_apb (
		.core_clk(core_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.req(req),
		.rd_data(rd_data)
	);
	// ------------------------------------------------------------
	// bus events
	// ------------------------------------------------------------
	always_comb begin
		scl_s = pin_s[1];
		sda_s = pin_s[0];
		rise = scl_s & ~c.scl_d;
		fall = ~scl_s & c.scl_d;
		start_ev = scl_s & c.scl_d & c.sda_d & ~sda_s;
		stop_ev = scl_s & c.scl_d & ~c.sda_d & sda_s;
		tdone = (c.tmr == 8'h00);
		rx_byte = {c.shift[6:0], c.samp};
		match = (((rx_byte[7:1] ^ c.own) & c.mask) == 7'h00);
	end
	// read mux, status nibble sits in the top of the control byte
	always_comb begin
		unique case (req.addr)
			`SMB_OFF_CTRL: rd_data = {24'h00_0000, c.ctrl};
			`SMB_OFF_CFG: rd_data = {29'h0000_0000, c.cfg};
			`SMB_OFF_DATA: rd_data = {24'h00_0000, c.data};
			`SMB_OFF_OWN: rd_data = {24'h00_0000, c.own, 1'b0};
			`SMB_OFF_MASK: rd_data = {24'h00_0000, c.mask, 1'b0};
			default: rd_data = 32'h0000_0000;
		endcase
	end
	// ------------------------------------------------------------
	// next step after a flag is served or an ack cycle ends
	// ------------------------------------------------------------
	function automatic smb_pkg::smb_core_type go_on(input smb_pkg::smb_core_type s);
		smb_pkg::smb_core_type r;
		r = s;
		r.pre_ack = 1'b0;
		r.sw_ack = 1'b0;
		r.bitcnt = 4'h0;
		r.sda_low = 1'b0;
		r.tmr = HALF;
		r.wrote = 1'b0;
		r.shift = s.data;
		if (s.stop_ctx || s.ctrl.arbitration_lost_flag) begin
			// transfer over, back to idle
			r.state = smb_pkg::SMB_IDLE;
			r.stop_ctx = 1'b0;
			r.scl_low = 1'b0;
			r.ctrl.tx = 1'b0;
		end else if (s.ctrl.master) begin
			if (s.ctrl.stop_request) begin
				r.state = smb_pkg::SMB_STOP;
				r.ph = 1'b0;
				r.sda_low = 1'b1;
			end else if (s.ctrl.start_request) begin
				r.state = smb_pkg::SMB_RSTART;
				r.ph = 1'b0;
			end else begin
				r.state = smb_pkg::SMB_BITS;
				r.ctrl.tx = s.wrote;
			end
		end else begin
			// slave: data written means transmit, else receive
			r.state = smb_pkg::SMB_BITS;
			r.ctrl.tx = s.wrote;
			r.scl_low = 1'b0;
		end
		return r;
	endfunction
	// ------------------------------------------------------------
	// core next state
	// ------------------------------------------------------------
	always_comb begin
		n = c;
		n.scl_d = scl_s;
		n.sda_d = sda_s;
		si_clr = 1'b0;
		if (!tdone) begin
			n.tmr = c.tmr - 8'h01;
		end
		// software writes first so hardware sets win
		if (req.wr) begin
			unique case (req.addr)
				`SMB_OFF_CTRL: begin
					n.ctrl.start_request = req.wdata[`SMB_CTRL_STA];
					n.ctrl.stop_request = req.wdata[`SMB_CTRL_STO];
					n.ctrl.ack = req.wdata[`SMB_CTRL_ACK];
					si_clr = c.ctrl.si & ~req.wdata[`SMB_CTRL_SI];
				end
				`SMB_OFF_CFG: n.cfg = req.wdata[2:0];
				`SMB_OFF_DATA: begin
					// data only taken while the flag is up
					if (c.ctrl.si) begin
						n.data = req.wdata[7:0];
						n.wrote = 1'b1;
					end
				end
				`SMB_OFF_OWN: n.own = req.wdata[7:1];
				`SMB_OFF_MASK: n.mask = req.wdata[7:1];
				default: n.wrote = c.wrote;
			endcase
		end
		if (si_clr) begin
			n.ctrl.si = 1'b0;
			n.ctrl.ack_request_flag = 1'b0;
			n.ctrl.arbitration_lost_flag = 1'b0;
		end
		// master clock generator, waits for a stretched clock
		if (c.ctrl.master && (c.state == smb_pkg::SMB_BITS || c.state == smb_pkg::SMB_ACK)) begin
			if (c.scl_low) begin
				if (tdone) begin
					n.scl_low = 1'b0;
					n.tmr = HALF;
				end
			end else if (!scl_s) begin
				n.tmr = HALF;
			end else if (tdone) begin
				n.scl_low = 1'b1;
				n.tmr = HALF;
			end
		end
		unique case (c.state)
			smb_pkg::SMB_IDLE: begin
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
				// start request on a free bus, also after our own stop
				if (c.cfg.enable && c.ctrl.start_request && !c.ctrl.si && scl_s && sda_s && !c.busy) begin
					n.ctrl.master = 1'b1;
					n.ctrl.tx = 1'b1;
					n.sda_low = 1'b1;
					n.tmr = HALF;
					n.state = smb_pkg::SMB_START;
				end
			end
			smb_pkg::SMB_START: begin
				if (c.ctrl.master) begin
					if (tdone) begin
						n.scl_low = 1'b1;
					end
					if (fall) begin
						n.state = smb_pkg::SMB_HOLD;
						n.ctrl.si = 1'b1;
					end
				end else if (fall) begin
					n.state = smb_pkg::SMB_BITS;
					n.bitcnt = 4'h0;
					n.addr_ph = 1'b1;
					n.ctrl.tx = 1'b0;
				end
			end
			smb_pkg::SMB_BITS: begin
				if (rise) begin
					n.samp = sda_s;
					// released a one but the line is low: lost arbitration
					if (c.ctrl.master && c.ctrl.tx && c.shift[7] && !sda_s) begin
						n.ctrl.arbitration_lost_flag = 1'b1;
						n.ctrl.master = 1'b0;
						n.ctrl.si = 1'b1;
						n.scl_low = 1'b0;
						n.state = smb_pkg::SMB_HOLD;
					end
				end
				if (fall) begin
					n.shift = rx_byte;
					n.bitcnt = c.bitcnt + 4'h1;
					if (c.bitcnt == `SMB_LAST_BIT) begin
						n.state = smb_pkg::SMB_ACK;
						n.data = rx_byte;
						n.sda_low = 1'b0;
						if (c.ctrl.tx) begin
							n.sda_low = 1'b0;
						end else if (c.cfg.hw_ack_enable) begin
							if (c.addr_ph && !match) begin
								n.state = smb_pkg::SMB_IDLE;
								n.ctrl.tx = 1'b0;
							end else if (c.addr_ph) begin
								n.sda_low = 1'b1;
							end else begin
								n.sda_low = c.ctrl.ack;
							end
						end else begin
							// flag before the ack cycle, software decides
							n.ctrl.si = 1'b1;
							n.ctrl.ack_request_flag = 1'b1;
							n.ctrl.start_request = c.addr_ph | c.ctrl.start_request;
							n.pre_ack = 1'b1;
							n.scl_low = 1'b1;
							n.state = smb_pkg::SMB_HOLD;
						end
					end
				end
			end
			smb_pkg::SMB_ACK: begin
				if (rise && c.ctrl.tx) begin
					n.ctrl.ack = ~sda_s;
				end
				if (fall) begin
					n.sda_low = 1'b0;
					n.addr_ph = 1'b0;
					if (c.mute_pend) begin
						n.state = smb_pkg::SMB_IDLE;
						n.mute_pend = 1'b0;
						n.sw_ack = 1'b0;
						n.scl_low = 1'b0;
						n.ctrl.tx = 1'b0;
					end else if (c.sw_ack) begin
						n = go_on(n);
					end else begin
						// flag after the ack cycle
						n.ctrl.si = 1'b1;
						n.ctrl.start_request = c.addr_ph | c.ctrl.start_request;
						n.scl_low = 1'b1;
						n.state = smb_pkg::SMB_HOLD;
					end
				end
			end
			smb_pkg::SMB_HOLD: begin
				n.scl_low = ~c.stop_ctx & ~c.ctrl.arbitration_lost_flag;
				if (si_clr) begin
					if (c.pre_ack) begin
						n.state = smb_pkg::SMB_ACK;
						n.pre_ack = 1'b0;
						n.sw_ack = 1'b1;
						n.sda_low = n.ctrl.ack;
						n.mute_pend = c.addr_ph & ~n.ctrl.ack;
						n.scl_low = c.ctrl.master;
						n.tmr = HALF;
					end else begin
						n = go_on(n);
					end
				end
			end
			smb_pkg::SMB_STOP: begin
				// data low under a released clock, then release data
				if (!c.ph) begin
					if (tdone) begin
						n.scl_low = 1'b0;
						n.ph = 1'b1;
						n.tmr = HALF;
					end
				end else if (!scl_s) begin
					n.tmr = HALF;
				end else if (tdone) begin
					n.sda_low = 1'b0;
					n.ctrl.master = 1'b0;
					n.ctrl.stop_request = 1'b0;
					n.ctrl.tx = 1'b0;
					n.state = smb_pkg::SMB_IDLE;
				end
			end
			smb_pkg::SMB_RSTART: begin
				// release data, release clock, then pull data low
				n.sda_low = 1'b0;
				if (!c.ph) begin
					if (tdone) begin
						n.scl_low = 1'b0;
						n.ph = 1'b1;
						n.tmr = HALF;
					end
				end else if (!scl_s) begin
					n.tmr = HALF;
				end else if (tdone) begin
					n.sda_low = 1'b1;
					n.ctrl.tx = 1'b1;
					n.tmr = HALF;
					n.state = smb_pkg::SMB_START;
				end
			end
			default: n.state = smb_pkg::SMB_IDLE;
		endcase
		// bus busy tracking and slave start and stop
		if (start_ev) begin
			n.busy = 1'b1;
		end
		if (stop_ev) begin
			n.busy = 1'b0;
		end
		if (!c.ctrl.master && c.cfg.enable) begin
			if (start_ev && !c.cfg.slave_inhibit) begin
				n.state = smb_pkg::SMB_START;
				n.mute_pend = 1'b0;
				n.sw_ack = 1'b0;
				n.pre_ack = 1'b0;
			end else if (stop_ev && c.state != smb_pkg::SMB_IDLE) begin
				if (c.addr_ph || c.state == smb_pkg::SMB_START) begin
					n.state = smb_pkg::SMB_IDLE;
				end else begin
					n.state = smb_pkg::SMB_HOLD;
					n.ctrl.si = 1'b1;
					n.ctrl.stop_request = 1'b1;
					n.ctrl.tx = 1'b0;
					n.stop_ctx = 1'b1;
				end
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
				n.addr_ph = 1'b0;
			end
		end
		if (!n.cfg.enable) begin
			n.state = smb_pkg::SMB_IDLE;
			n.ctrl.master = 1'b0;
			n.scl_low = 1'b0;
			n.sda_low = 1'b0;
		end
		if (n.state == smb_pkg::SMB_BITS) begin
			n.sda_low = n.ctrl.tx & ~n.shift[7];
		end
		if (n.ctrl.si && !c.ctrl.si) begin
			n.wrote = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			c <= '0;
			c.own <= `SMB_OWN_RST;
			c.mask <= `SMB_MASK_RST;
			c.scl_d <= 1'b1;
			c.sda_d <= 1'b1;
		end else begin
			c <= n;
		end
	end
	// open-drain drive: enable pulls the line low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = c.scl_low;
	assign sda_oe = c.sda_low;
endmodule
`default_nettype wire

/* File: bench/smb_core_sva.sv */
// port assertions for the serial bus block
`timescale 1ns/100ps
`default_nettype none
module smb_core_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic acc; // access phase of a transfer
	logic hit; // offset lands on a register
	assign acc = psel && penable;
	assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing in access");
	property p_err; acc && !hit |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; acc && hit |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("mapped access refused");
	property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("line driven high");
	property p_rst; disable iff (1'b0) rst |=> !scl_oe && !sda_oe; endproperty
	a_rst: assert property (p_rst) else $error("line pulled after reset");
	property p_hi; prdata[31:8] == 24'h000000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_prd; !(psel && !penable) |=> $stable(prdata); endproperty
	a_prd: assert property (p_prd) else $error("read data moved");
	property p_str; $rose(scl_oe) |-> scl_oe [*4]; endproperty
	a_str: assert property (p_str) else $error("clock hold too short");
endmodule
bind smb_core smb_core_chk smb_core_chk_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

/* File: bench/smb_far_master.sv */
// behavioural far-end bus master, 170 ns bit period
`timescale 1ns/100ps
`default_nettype none
module smb_far_master (
	input wire logic core_clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_dn,
	output logic sda_dn
);
	initial begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
	end
	// wait n core cycles
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// release clock, wait out any stretch, hold high
	task automatic rise();
		scl_dn <= 1'b0;
		tk(1);
		while (scl !== 1'b1) tk(1);
		tk(8);
	endtask
	// one bit: level set mid low phase, line sampled at end of high
	task automatic bit_io(input logic v, output logic s);
		tk(4);
		sda_dn <= ~v;
		tk(4);
		rise();
		s = sda;
		scl_dn <= 1'b1;
	endtask
	// start, also usable as repeated start
	task automatic start();
		sda_dn <= 1'b0;
		rise();
		sda_dn <= 1'b1;
		tk(8);
		scl_dn <= 1'b1;
	endtask
	// eight bits msb first, then the ack bit
	task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(~ack_in, ack_out);
		ack_out = ~ack_out;
	endtask
	// stop condition, then bus left idle
	task automatic stop();
		tk(4);
		sda_dn <= 1'b1;
		tk(4);
		rise();
		sda_dn <= 1'b0;
		tk(8);
	endtask
endmodule
`default_nettype wire

/* File: bench/test_smb_slave_read_status_decode.sv */
// self-checking bench for the serial bus block
`timescale 1ns/100ps
`default_nettype none
module test_smb_slave_read_status_decode;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, r;
	logic [31:0] seed = 32'd47971;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, scl_dn, sda_dn, err, ak;
	logic ph2 = 1'b0; // second address phase reached
	logic [7:0] rx, d0, d1;
	wire scl;
	wire sda;
	int errors = 0;
	int compares = 0;
	// wired lines with pull-ups
	assign scl = ~scl_oe & ~scl_dn;
	assign sda = ~sda_oe & ~sda_dn;
	always #5 core_clk = ~core_clk;
	smb_core smb_core_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe));
	smb_far_master smb_far_master_inst (.core_clk(core_clk), .scl(scl), .sda(sda),
		.scl_dn(scl_dn), .sda_dn(sda_dn));
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, idle edge after it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	// poll control until a bit reaches a level
	task automatic wait_ctrl(input int b, input logic v);
		for (int n = 0; n < 3000; n++) begin
			apb(1'b0, 8'h00, 32'h0);
			if (rd[b] === v) break;
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// reset values, unmapped offset
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'hFE);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("registers done");
		// master start, unanswered address, stop then start
		r = rnd();
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h20);
		wait_ctrl(0, 1'b1);
		chk(rd & 32'hFD, 32'hE1);
		apb(1'b1, 8'h08, {24'h0, r[7:1], 1'b0});
		apb(1'b1, 8'h00, 32'h0);
		wait_ctrl(0, 1'b1);
		chk(rd, 32'hC1);
		apb(1'b1, 8'h00, 32'h30);
		wait_ctrl(0, 1'b1);
		chk(rd & 32'hFD, 32'hE1);
		apb(1'b1, 8'h00, 32'h10);
		wait_ctrl(7, 1'b0);
		chk(rd & 32'hF0, 32'h0);
		$display("master done");
		// slave read, software acknowledge
		r = rnd();
		d0 = r[15:8];
		d1 = r[23:16];
		apb(1'b1, 8'h04, 32'h1);
		fork
			begin
				smb_far_master_inst.start();
				smb_far_master_inst.byte_io({r[6:0], 1'b1}, 1'b0, rx, ak);
				chk(ak, 32'h1);
				smb_far_master_inst.byte_io(8'hFF, 1'b1, rx, ak);
				chk(rx, d0);
				smb_far_master_inst.byte_io(8'hFF, 1'b0, rx, ak);
				chk(rx, d1);
				smb_far_master_inst.stop();
			end
			begin
				wait_ctrl(0, 1'b1);
				chk(rd & 32'hFD, 32'h29);
				// data register touched only while the flag is up
				apb(1'b1, 8'h08, {24'h0, d0});
				apb(1'b1, 8'h00, 32'h2);
				wait_ctrl(0, 1'b1);
				chk(rd, 32'h43);
				apb(1'b1, 8'h08, {24'h0, d1});
				apb(1'b1, 8'h00, 32'h2);
				wait_ctrl(0, 1'b1);
				chk(rd, 32'h41);
				apb(1'b1, 8'h00, 32'h0);
				wait_ctrl(0, 1'b1);
				chk(rd & 32'hFD, 32'h11);
				apb(1'b1, 8'h00, 32'h0);
			end
		join
		$display("slave software ack done");
		// hardware ack: foreign address rejected, own address taken
		r = rnd();
		d0 = 8'h00;
		apb(1'b1, 8'h0C, {24'h0, r[6:0], 1'b0});
		apb(1'b1, 8'h04, 32'h5);
		fork
			begin
				smb_far_master_inst.start();
				smb_far_master_inst.byte_io({r[6:0] ^ 7'h01, 1'b1}, 1'b0, rx, ak);
				chk(ak, 32'h0);
				ph2 = 1'b1;
				smb_far_master_inst.start();
				smb_far_master_inst.byte_io({r[6:0], 1'b1}, 1'b0, rx, ak);
				chk(ak, 32'h1);
				smb_far_master_inst.byte_io(8'hFF, 1'b0, rx, ak);
				chk(rx, d0);
				smb_far_master_inst.stop();
			end
			begin
				wait_ctrl(0, 1'b1);
				chk(ph2, 32'h1);
				chk(rd & 32'hFD, 32'h21);
				chk(scl_oe, 32'h1);
				apb(1'b1, 8'h08, {24'h0, d0});
				apb(1'b1, 8'h00, 32'h0);
				wait_ctrl(0, 1'b1);
				chk(rd & 32'hFD, 32'h41);
				apb(1'b1, 8'h00, 32'h0);
				wait_ctrl(0, 1'b1);
				chk(rd & 32'hFD, 32'h11);
				apb(1'b1, 8'h00, 32'h0);
			end
		join
		$display("slave hardware ack done");
		wrap_up();
	end
endmodule
`default_nettype wire
